// *** uip_pkg.sv ***
/*
 * uip_pkg: offsets, field positions, trigger levels and interrupt
 * identification codes for the uart interrupt identification block.
 * Assumes an 8-bit register port with 3-bit addresses.
 */
package uip_pkg;

   // register offsets
   localparam logic [2:0] UIP_ADDR_IDENT = 3'h2;  // read: identification
   localparam logic [2:0] UIP_ADDR_FTC   = 3'h2;  // write: threshold control
   localparam logic [2:0] UIP_ADDR_EFR   = 3'h3;  // enhanced function control
   localparam logic [2:0] UIP_ADDR_EVT   = 3'h4;  // sticky events, w1c
   localparam logic [2:0] UIP_ADDR_MASK  = 3'h5;  // event mask

   // threshold control and enhanced function fields
   localparam int UIP_FTC_EN     = 0;
   localparam int UIP_FTC_TX_LO  = 4;
   localparam int UIP_FTC_RX_LO  = 6;
   localparam int UIP_EFR_ENH    = 4;

   // reset values
   localparam logic [7:0] UIP_FTC_RST   = 8'h00;
   localparam logic [7:0] UIP_EFR_RST   = 8'h00;
   localparam logic [6:0] UIP_MASK_RST  = 7'h00;
   localparam logic [7:0] UIP_IDENT_RST = 8'h01;

   // source indices, highest priority first
   localparam int UIP_NSRC     = 7;
   localparam int UIP_SRC_LS   = 0;
   localparam int UIP_SRC_RDA  = 1;
   localparam int UIP_SRC_TOUT = 2;
   localparam int UIP_SRC_THRE = 3;
   localparam int UIP_SRC_MSR  = 4;
   localparam int UIP_SRC_XOFF = 5;
   localparam int UIP_SRC_FLOW = 6;

   // identification codes, bits 5:0, and fifo bits 7:6
   localparam logic [5:0] UIP_CODE_NONE = 6'h01;
   localparam logic [5:0] UIP_CODE_LS   = 6'h06;
   localparam logic [5:0] UIP_CODE_RDA  = 6'h04;
   localparam logic [5:0] UIP_CODE_TOUT = 6'h0C;
   localparam logic [5:0] UIP_CODE_THRE = 6'h02;
   localparam logic [5:0] UIP_CODE_MSR  = 6'h00;
   localparam logic [5:0] UIP_CODE_XOFF = 6'h10;
   localparam logic [5:0] UIP_CODE_FLOW = 6'h20;
   localparam logic [1:0] UIP_FIFO_ON   = 2'h3;
   localparam logic [1:0] UIP_FIFO_OFF  = 2'h0;

   // trigger levels in characters
   localparam logic [6:0] UIP_RX_LVL0 = 7'h08;
   localparam logic [6:0] UIP_RX_LVL1 = 7'h10;
   localparam logic [6:0] UIP_RX_LVL2 = 7'h38;
   localparam logic [6:0] UIP_RX_LVL3 = 7'h3C;
   localparam logic [6:0] UIP_TX_LVL0 = 7'h08;
   localparam logic [6:0] UIP_TX_LVL1 = 7'h10;
   localparam logic [6:0] UIP_TX_LVL2 = 7'h20;
   localparam logic [6:0] UIP_TX_LVL3 = 7'h38;

endpackage

// *** uip_thresh.sv ***
/*
 * uip_thresh: compares a fifo fill count with a trigger level and gives
 * level and one-cycle edge indications.
 * Assumes count and level are synchronous to mclk.
 */
`timescale 1ns/1ps
module uip_thresh
   import uip_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       srst,
   input  wire logic [6:0] count,
   input  wire logic [6:0] level,
   output logic            at_level,
   output logic            below,
   output logic            reach_pulse,
   output logic            below_pulse
);
   logic at_q;
   logic below_q;

   assign at_level    = (count == level);
   assign below       = (count < level);
   assign reach_pulse = at_level & ~at_q;
   assign below_pulse = below & ~below_q;

   // previous comparison results for edge detection
   always_ff @(posedge mclk) begin
      if (srst) begin
         at_q    <= 1'b0;
         below_q <= 1'b0;
      end else begin
         at_q    <= at_level;
         below_q <= below;
      end
   end
endmodule

// *** uip_prio.sv ***
/*
 * uip_prio: picks the highest-priority pending source and gives its
 * index and whether any source is pending.
 * Assumes bit 0 of the pending vector is the highest priority.
 */
`timescale 1ns/1ps
module uip_prio
   import uip_pkg::*;
(
   input  wire logic [6:0] pend,
   output logic            any,
   output logic [2:0]      idx
);
   always_comb begin
      any = 1'b0;
      idx = 3'h0;
      for (int i = UIP_NSRC - 1; i >= 0; i--) begin
         if (pend[i]) begin
            any = 1'b1;
            idx = 3'(i);
         end
      end
   end
endmodule

// *** uip_irq_ident.sv ***
/*
 * uip_irq_ident: interrupt identification, trigger thresholds and event
 * interrupt for one uart channel.
 * Assumes source conditions come from the receive, transmit, modem and
 * flow-control logic, synchronous to mclk; pulses are one cycle long.
 */
`timescale 1ns/1ps
module uip_irq_ident
   import uip_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       srst,
   input  wire logic [2:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic [7:0]      reg_rdata,
   input  wire logic       line_status_evt,
   input  wire logic [6:0] rx_count,
   input  wire logic       rx_timeout_evt,
   input  wire logic [6:0] tx_count,
   input  wire logic       modem_change_evt,
   input  wire logic       xoff_match_evt,
   input  wire logic       xon_match_evt,
   input  wire logic       flow_change_evt,
   output logic            fifo_enable,
   output logic [6:0]      rx_trigger_level,
   output logic [6:0]      tx_trigger_level,
   output logic            irq
);
   logic [7:0] ftc_q;
   logic [7:0] efr_q;
   logic [6:0] pend_q;
   logic [6:0] pend_v;
   logic [6:0] set_v;
   logic [6:0] clr_v;
   logic [2:0] cur_q;
   logic       cur_v_q;
   logic       sel_any;
   logic [2:0] sel_idx;
   logic       hold;
   logic [2:0] rep_idx;
   logic       rep_v;
   logic [5:0] rep_code;
   logic [7:0] ident;
   logic [6:0] evt_q;
   logic [6:0] mask_q;
   logic [7:0] rdata_d;
   logic       enh;
   logic       rx_at;
   logic       rx_below;
   logic       rx_reach;
   logic       tx_below_p;
   logic       id_rd;

   assign enh         = efr_q[UIP_EFR_ENH];
   assign fifo_enable = ftc_q[UIP_FTC_EN];
   assign id_rd       = reg_rd & (reg_addr == UIP_ADDR_IDENT);

   // threshold control and enhanced function registers
   always_ff @(posedge mclk) begin
      if (srst) begin
         ftc_q <= UIP_FTC_RST;
      end else if (reg_wr && reg_addr == UIP_ADDR_FTC) begin
         if (reg_wdata[UIP_FTC_EN]) begin
            ftc_q <= reg_wdata;
         end else begin
            ftc_q[UIP_FTC_EN] <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         efr_q <= UIP_EFR_RST;
      end else if (reg_wr && reg_addr == UIP_ADDR_EFR) begin
         efr_q <= reg_wdata;
      end
   end

   // trigger level selection
   always_comb begin
      unique case (ftc_q[UIP_FTC_RX_LO +: 2])
         2'h0: rx_trigger_level = UIP_RX_LVL0;
         2'h1: rx_trigger_level = UIP_RX_LVL1;
         2'h2: rx_trigger_level = UIP_RX_LVL2;
         2'h3: rx_trigger_level = UIP_RX_LVL3;
      endcase
      unique case (ftc_q[UIP_FTC_TX_LO +: 2])
         2'h0: tx_trigger_level = UIP_TX_LVL0;
         2'h1: tx_trigger_level = UIP_TX_LVL1;
         2'h2: tx_trigger_level = UIP_TX_LVL2;
         2'h3: tx_trigger_level = UIP_TX_LVL3;
      endcase
   end

   uip_thresh u_rx_thresh (
      .mclk        (mclk),
      .srst        (srst),
      .count       (rx_count),
      .level       (rx_trigger_level),
      .at_level    (rx_at),
      .below       (rx_below),
      .reach_pulse (rx_reach),
      .below_pulse ()
   );

   uip_thresh u_tx_thresh (
      .mclk        (mclk),
      .srst        (srst),
      .count       (tx_count),
      .level       (tx_trigger_level),
      .at_level    (),
      .below       (),
      .reach_pulse (),
      .below_pulse (tx_below_p)
   );

   // source set and clear terms
   always_comb begin
      set_v               = '0;
      clr_v               = '0;
      set_v[UIP_SRC_LS]   = line_status_evt;
      set_v[UIP_SRC_RDA]  = rx_reach;
      set_v[UIP_SRC_TOUT] = rx_timeout_evt;
      set_v[UIP_SRC_THRE] = tx_below_p;
      set_v[UIP_SRC_MSR]  = modem_change_evt;
      set_v[UIP_SRC_XOFF] = xoff_match_evt & enh;
      set_v[UIP_SRC_FLOW] = flow_change_evt & enh;
      clr_v[UIP_SRC_RDA]  = rx_below;
      clr_v[UIP_SRC_XOFF] = xon_match_evt | ~enh;
      clr_v[UIP_SRC_FLOW] = ~enh;
      if (id_rd && rep_v && rep_idx != 3'(UIP_SRC_XOFF)) begin
         clr_v[rep_idx] = 1'b1;
      end
   end

   // pending flags, set wins over clear
   always_ff @(posedge mclk) begin
      if (srst) begin
         pend_q <= '0;
      end else begin
         pend_q <= (pend_q & ~clr_v) | set_v;
      end
   end

   // xoff and flow sources hidden while enhanced functions are off
   always_comb begin
      pend_v               = pend_q;
      pend_v[UIP_SRC_XOFF] = pend_q[UIP_SRC_XOFF] & enh;
      pend_v[UIP_SRC_FLOW] = pend_q[UIP_SRC_FLOW] & enh;
   end

   uip_prio u_prio (
      .pend (pend_v),
      .any  (sel_any),
      .idx  (sel_idx)
   );

   // reported source held while still pending
   assign hold    = cur_v_q & pend_v[cur_q];
   assign rep_idx = hold ? cur_q : sel_idx;
   assign rep_v   = hold | sel_any;

   always_ff @(posedge mclk) begin
      if (srst) begin
         cur_q   <= 3'h0;
         cur_v_q <= 1'b0;
      end else begin
         cur_q   <= rep_idx;
         cur_v_q <= rep_v;
      end
   end

   // identification code
   always_comb begin
      rep_code = UIP_CODE_NONE;
      if (rep_v) begin
         unique case (rep_idx)
            3'h0:    rep_code = UIP_CODE_LS;
            3'h1:    rep_code = UIP_CODE_RDA;
            3'h2:    rep_code = UIP_CODE_TOUT;
            3'h3:    rep_code = UIP_CODE_THRE;
            3'h4:    rep_code = UIP_CODE_MSR;
            3'h5:    rep_code = UIP_CODE_XOFF;
            3'h6:    rep_code = UIP_CODE_FLOW;
            default: rep_code = UIP_CODE_NONE;
         endcase
      end
   end

   assign ident = {(fifo_enable ? UIP_FIFO_ON : UIP_FIFO_OFF), rep_code};

   // sticky event status and mask
   always_ff @(posedge mclk) begin
      if (srst) begin
         evt_q <= '0;
      end else begin
         if (reg_wr && reg_addr == UIP_ADDR_EVT) begin
            evt_q <= (evt_q & ~reg_wdata[6:0]) | set_v;
         end else begin
            evt_q <= evt_q | set_v;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         mask_q <= UIP_MASK_RST;
      end else if (reg_wr && reg_addr == UIP_ADDR_MASK) begin
         mask_q <= reg_wdata[6:0];
      end
   end

   assign irq = |(evt_q & mask_q);

   // read data, one cycle after the strobe
   always_comb begin
      unique case (reg_addr)
         UIP_ADDR_IDENT: rdata_d = ident;
         UIP_ADDR_EFR:   rdata_d = efr_q;
         UIP_ADDR_EVT:   rdata_d = {1'b0, evt_q};
         UIP_ADDR_MASK:  rdata_d = {1'b0, mask_q};
         default:        rdata_d = 8'h00;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= rdata_d;
      end
   end
endmodule

// *** uip_irq_ident_asserts.sv ***
/* uip_irq_ident_asserts: port checks for uip_irq_ident.
   assumes a bind from the testbench top and the single mclk domain. */
`timescale 1ns/1ps
module uip_irq_ident_asserts
   import uip_pkg::*;
(
   input wire logic       mclk,
   input wire logic       srst,
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic       fifo_enable,
   input wire logic [6:0] rx_trigger_level,
   input wire logic [6:0] tx_trigger_level,
   input wire logic       irq
);
   logic       enh_q;
   logic       ftc_w;
   logic       id_r;
   assign ftc_w = reg_wr && reg_addr == UIP_ADDR_FTC;
   assign id_r  = reg_rd && reg_addr == UIP_ADDR_IDENT;
   always_ff @(posedge mclk) begin
      if (srst) begin
         enh_q <= 1'b0;
      end else if (reg_wr && reg_addr == UIP_ADDR_EFR) begin
         enh_q <= reg_wdata[UIP_EFR_ENH];
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (srst);
   fifo_en_a: assert property (ftc_w |=> fifo_enable == $past(reg_wdata[0]))
      else $error("fifo enable wrong");
   ftc_refuse_a: assert property (ftc_w && !reg_wdata[0] |=>
      $stable(rx_trigger_level) && $stable(tx_trigger_level))
      else $error("refused write changed levels");
   rx_level_a: assert property (ftc_w && reg_wdata[0] ##1 1'b1 |->
      rx_trigger_level == ($past(reg_wdata[7]) ? ($past(reg_wdata[6]) ?
      7'h3C : 7'h38) : ($past(reg_wdata[6]) ? 7'h10 : 7'h08)))
      else $error("rx level wrong");
   tx_level_a: assert property (ftc_w && reg_wdata[0] ##1 1'b1 |->
      tx_trigger_level == ($past(reg_wdata[5]) ? ($past(reg_wdata[4]) ?
      7'h38 : 7'h20) : ($past(reg_wdata[4]) ? 7'h10 : 7'h08)))
      else $error("tx level wrong");
   ident_code_a: assert property (id_r |=> reg_rdata[5:0] inside
      {6'h01, 6'h06, 6'h04, 6'h0C, 6'h02, 6'h00, 6'h10, 6'h20})
      else $error("illegal ident code");
   fifo_bits_a: assert property (id_r |=>
      reg_rdata[7:6] == {2{$past(fifo_enable)}}) else $error("fifo bits");
   none_bit_a: assert property (id_r ##1 reg_rdata[0] |->
      reg_rdata[5:1] == 5'h00) else $error("bit 0 with a source");
   enh_off_a: assert property (id_r && !enh_q |=>
      reg_rdata[5:4] == 2'h0) else $error("bits 5:4 without enhance");
   reset_out_a: assert property ($fell(srst) |-> !irq &&
      !fifo_enable && reg_rdata == 8'h00) else $error("reset outputs");
   cover property (id_r ##1 reg_rdata[5:0] == UIP_CODE_LS);
   cover property (ftc_w && !reg_wdata[0]);
   cover property ($rose(irq));
endmodule

// *** uip_host.sv ***
/* uip_host: host processor model on the register port.
   assumes one-cycle strobes and read data in the cycle after. */
`timescale 1ns/1ps
module uip_host
   import uip_pkg::*;
(
   input  wire logic       mclk,
   output logic [2:0]      reg_addr,
   output logic [7:0]      reg_wdata,
   output logic            reg_wr,
   output logic            reg_rd,
   input  wire logic [7:0] reg_rdata
);
   initial begin
      reg_addr = 3'h0;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      @(posedge mclk);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_wr    <= 1'b1;
      @(posedge mclk);
      reg_wr    <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, output logic [7:0] v);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge mclk);
      reg_rd   <= 1'b0;
      #1 v = reg_rdata;
   endtask
   // threshold writes always carry the fifo enable bit
   task automatic ftc(input logic [7:0] v);
      wr(UIP_ADDR_FTC, v | 8'h01);
   endtask
endmodule

// *** testbench.sv ***
/* testbench: drives uip_irq_ident through the host model and the
   source inputs; assumes the host model owns the register strobes. */
`timescale 1ns/1ps
module testbench;
   import uip_pkg::*;
   logic       mclk, srst, reg_wr, reg_rd, fifo_enable, irq;
   logic [2:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, d;
   logic [6:0] rx_count, tx_count, rx_trigger_level, tx_trigger_level;
   logic [5:0] ev;
   int         err_count, n_checks;
   logic [6:0] rx_tab [4] = '{7'h08, 7'h10, 7'h38, 7'h3C};
   logic [6:0] tx_tab [4] = '{7'h08, 7'h10, 7'h20, 7'h38};
   logic [7:0] pri_tab [6] = '{8'hC2, 8'hC6, 8'hCC, 8'hC0, 8'hE0, 8'hC1};
   uip_host u_uip_host (.mclk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata);
   uip_irq_ident u_uip_irq_ident (.mclk, .srst, .reg_addr, .reg_wdata,
      .reg_wr, .reg_rd, .reg_rdata, .line_status_evt(ev[0]), .rx_count,
      .rx_timeout_evt(ev[1]), .tx_count, .modem_change_evt(ev[2]),
      .xoff_match_evt(ev[3]), .xon_match_evt(ev[4]),
      .flow_change_evt(ev[5]), .fifo_enable, .rx_trigger_level,
      .tx_trigger_level, .irq);
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic rdc(input logic [2:0] a, input logic [7:0] exp);
      u_uip_host.rd(a, d);
      chk(d, exp);
   endtask
   task automatic pulse(input logic [5:0] v);
      @(posedge mclk);
      ev <= v;
      @(posedge mclk);
      ev <= 6'h00;
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   initial begin
      #2000000;
      err_count++;
      tally_and_finish();
   end
   initial begin
      srst = 1'b1;
      ev = 6'h00;
      rx_count = 7'h00;
      tx_count = 7'h3F;
      repeat (4) @(posedge mclk);
      srst <= 1'b0;
      rdc(UIP_ADDR_IDENT, 8'h01);
      u_uip_host.wr(UIP_ADDR_FTC, 8'hF0);
      #1 chk({7'h00, fifo_enable}, 8'h00);
      chk({1'b0, rx_trigger_level}, 8'h08);
      for (int i = 0; i < 4; i++) begin
         u_uip_host.ftc({i[1:0], i[1:0], 4'h0});
         #1 chk({1'b0, rx_trigger_level}, {1'b0, rx_tab[i]});
         chk({1'b0, tx_trigger_level}, {1'b0, tx_tab[i]});
      end
      u_uip_host.ftc(8'h00);
      u_uip_host.wr(UIP_ADDR_EFR, 8'h10);
      $display("test thresholds done");
      @(posedge mclk);
      tx_count <= 7'h00;
      pulse(6'h27);
      foreach (pri_tab[k]) rdc(UIP_ADDR_IDENT, pri_tab[k]);
      $display("test priority done");
      @(posedge mclk);
      rx_count <= 7'h07;
      @(posedge mclk);
      rx_count <= 7'h08;
      rdc(UIP_ADDR_IDENT, 8'hC4);
      @(posedge mclk);
      rx_count <= 7'h07;
      @(posedge mclk);
      rx_count <= 7'h08;
      @(posedge mclk);
      rx_count <= 7'h07;
      rdc(UIP_ADDR_IDENT, 8'hC1);
      pulse(6'h08);
      rdc(UIP_ADDR_IDENT, 8'hD0);
      rdc(UIP_ADDR_IDENT, 8'hD0);
      pulse(6'h10);
      rdc(UIP_ADDR_IDENT, 8'hC1);
      u_uip_host.wr(UIP_ADDR_EFR, 8'h00);
      pulse(6'h20);
      rdc(UIP_ADDR_IDENT, 8'hC1);
      $display("test sources done");
      u_uip_host.wr(UIP_ADDR_EVT, 8'h7F);
      u_uip_host.wr(UIP_ADDR_MASK, 8'h01);
      pulse(6'h01);
      #1 chk({7'h00, irq}, 8'h01);
      rdc(UIP_ADDR_EVT, 8'h01);
      u_uip_host.wr(UIP_ADDR_MASK, 8'h00);
      #1 chk({7'h00, irq}, 8'h00);
      u_uip_host.wr(UIP_ADDR_MASK, 8'h01);
      #1 chk({7'h00, irq}, 8'h01);
      u_uip_host.wr(UIP_ADDR_EVT, 8'h01);
      #1 chk({7'h00, irq}, 8'h00);
      rdc(UIP_ADDR_IDENT, 8'hC6);
      rdc(3'h0, 8'h00);
      $display("test interrupt done");
      tally_and_finish();
   end
endmodule
bind uip_irq_ident uip_irq_ident_asserts u_chk (.mclk, .srst, .reg_addr,
   .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .fifo_enable,
   .rx_trigger_level, .tx_trigger_level, .irq);
